// >>> bench/cpsif_properties.sv
// Interface-level property checks for the core control block
`timescale 1ns/1ns
module cpsif_properties (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [8:0]  fadr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        do_call,
    input wire logic        do_goto,
    input wire logic        do_irq_push,
    input wire logic        do_return,
    input wire logic [10:0] jump_target,
    input wire logic [12:0] pc,
    input wire logic        irq,
    input wire logic        ev_conv,
    input wire logic        ev_t1_ovf,
    input wire logic        por_event,
    input wire logic        bor_event
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Any push or pop between a call and its return would spoil the pairing
    wire stk_busy = do_call || do_irq_push || do_return;
    wire lat_wr   = wr && fadr == cpsif_pkg::ADR_LATCH;
    wire pcl_wr   = wr && fadr == cpsif_pkg::ADR_PCL && !stk_busy && !do_goto;

    a_call_target: assert property (do_call && !do_return |=>
        pc[10:0] == $past(jump_target)) else $error("call target not loaded");
    a_goto_target: assert property (do_goto && !do_return |=>
        pc[10:0] == $past(jump_target)) else $error("goto target not loaded");
    a_latch_load: assert property (lat_wr ##1 !lat_wr ##1 pcl_wr |=>
        {3'b000, pc[12:8]} == ($past(wdata, 3) & 8'h1f) && pc[7:0] == $past(wdata))
        else $error("upper counter bits not taken from latch");
    a_call_return: assert property (do_call && !do_return ##1 !stk_busy [*2] ##1 do_return |=>
        pc == 13'($past(pc, 4) + 13'h0001)) else $error("return address wrong");
    a_flags_mask: assert property (rd && fadr == cpsif_pkg::ADR_FLAGS_A |=>
        (rdata & ~cpsif_pkg::FLAGS_A_MASK) == 8'h00) else $error("unused flag bits set");
    a_cause_mask: assert property (rd && fadr == cpsif_pkg::ADR_RST_CAUSE |=>
        rdata[7:2] == 6'h00) else $error("unused cause bits set");
    a_t1_sets: assert property (ev_t1_ovf ##1 !wr ##1 rd && fadr == cpsif_pkg::ADR_FLAGS_A |=>
        rdata[cpsif_pkg::B_T1]) else $error("overflow flag not set");
    a_conv_sets: assert property (ev_conv ##1 !wr ##1 rd && fadr == cpsif_pkg::ADR_FLAGS_A |=>
        rdata[cpsif_pkg::B_CONV]) else $error("conversion flag not set");
    a_por_clears: assert property (por_event ##1 !wr ##1 rd && fadr == cpsif_pkg::ADR_RST_CAUSE
        |=> !rdata[cpsif_pkg::B_POR]) else $error("power-on bit not cleared");
    a_bor_clears: assert property (bor_event ##1 !wr ##1 rd && fadr == cpsif_pkg::ADR_RST_CAUSE
        |=> !rdata[cpsif_pkg::B_BOR]) else $error("brown-out bit not cleared");
    a_reset_pc: assert property ($rose(rst_b) |-> pc == 13'h0000)
        else $error("counter not cleared by reset");

    // Main scenarios reached
    c_call_return: cover property (do_call ##1 !stk_busy [*2] ##1 do_return);
    c_irq_rise: cover property ($rose(irq));
    c_por_read: cover property (por_event ##2 rd);
endmodule : cpsif_properties

// >>> bench/tb.sv
// Self-checking bench: CPU end and control block joined over the interface
`timescale 1ns/1ns
module tb;
    logic        ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, u_wr = 1'b0, u_rd = 1'b0;
    logic        u_call = 1'b0, u_goto = 1'b0, u_irq_push = 1'b0, u_return = 1'b0;
    logic        u_step = 1'b0, u_por = 1'b0, u_bor = 1'b0, u_irq, file_wr;
    logic [8:0]  u_adr = 9'h000, file_adr, seen_adr, fa;
    logic [7:0]  u_wdata = 8'h00, u_status = 8'h00, file_rdata = 8'h00, rv, lat, pc_low_byte, d;
    logic [7:0]  u_rdata, pointer_q, latch_q, file_wdata, seen_wd;
    logic [10:0] u_target = 11'h000;
    logic [7:0]  u_events = 8'h00;
    logic [1:0]  u_ccp_mode = 2'h0;
    logic [12:0] u_pc, epc;
    logic [12:0] stk[$];
    int          n_errors = 0, cmp_count = 0, seed = 58915, n_fwr = 0, f0;

    always #2 ref_clk = ~ref_clk;

    cpsif_if bus ();
    cpsif_core i_cpsif_core (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .bus(bus.core),
        .file_adr(file_adr), .file_wdata(file_wdata), .file_wr(file_wr),
        .file_rdata(file_rdata), .pointer_q(pointer_q), .latch_q(latch_q));
    cpsif_cpu i_cpsif_cpu (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .bus(bus.cpu),
        .u_adr(u_adr), .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_status(u_status),
        .u_call(u_call), .u_goto(u_goto), .u_irq_push(u_irq_push), .u_return(u_return),
        .u_step(u_step), .u_target(u_target), .u_events(u_events), .u_ccp_mode(u_ccp_mode),
        .u_por(u_por), .u_bor(u_bor), .u_rdata(u_rdata), .u_pc(u_pc), .u_irq(u_irq));
    cpsif_properties i_cpsif_properties (.ref_clk(ref_clk), .rst_b(rst_b), .fadr(bus.fadr),
        .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .do_call(bus.do_call),
        .do_goto(bus.do_goto), .do_irq_push(bus.do_irq_push), .do_return(bus.do_return),
        .jump_target(bus.jump_target), .pc(bus.pc), .irq(bus.irq), .ev_conv(bus.ev_conv),
        .ev_t1_ovf(bus.ev_t1_ovf), .por_event(bus.por_event), .bor_event(bus.bor_event));

    // Record forwarded file writes; the pulse is seen at the edge after it lands
    always @(posedge ref_clk) begin
        if (file_wr === 1'b1) begin
            n_fwr <= n_fwr + 1;
            seen_adr <= file_adr;
            seen_wd <= file_wdata;
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t counter %h expected %h", $time, got, exp);
        end
    endtask : chk13

    task automatic wreg(input logic [8:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        u_adr <= a;
        u_wdata <= v;
        u_wr <= 1'b1;
        @(posedge ref_clk);
        u_wr <= 1'b0;
    endtask : wreg

    // Read data reach u_rdata one edge after the core takes the strobe
    task automatic rreg(input logic [8:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        u_adr <= a;
        u_rd <= 1'b1;
        @(posedge ref_clk);
        u_rd <= 1'b0;
        @(posedge ref_clk);
        #1 v = u_rdata;
    endtask : rreg

    task automatic ev(input logic [7:0] m, input logic p, input logic b);
        @(posedge ref_clk);
        u_events <= m;
        u_por <= p;
        u_bor <= b;
        @(posedge ref_clk);
        {u_events, u_por, u_bor} <= 10'h000;
    endtask : ev

    // Flow pulse: 0 call, 1 goto, 2 interrupt push, 3 return, 4 step; keeps a stack model
    task automatic flow(input int k, input logic [10:0] t);
        @(posedge ref_clk);
        {u_call, u_goto, u_irq_push, u_return, u_step} <= 5'h10 >> k;
        u_target <= t;
        @(posedge ref_clk);
        {u_call, u_goto, u_irq_push, u_return, u_step} <= 5'h00;
        if (k == 0 || k == 2) stk.push_back(k == 0 ? 13'(epc + 13'h0001) : epc);
        if (stk.size() > 8) void'(stk.pop_front());
        if (k < 2) epc = {lat[4:3], t};
        if (k == 3) epc = stk.pop_back();
        if (k == 4) epc = 13'(epc + 13'h0001);
        @(posedge ref_clk);
        #1 chk13(u_pc, epc);
    endtask : flow

    // Event bit k of u_events to the flag bit it must set; bits 6 and 7 land in flags_b
    function automatic logic [7:0] fbit(input int k);
        logic [7:0] t [8] = '{8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h10, 8'h08};
        return t[k];
    endfunction : fbit

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rreg(cpsif_pkg::ADR_RST_CAUSE, rv);
        chk8(rv, 8'h03);
        chk13(u_pc, 13'h0000);
        for (int k = 0; k < 8; k++) begin
            fa = (k >= 6) ? cpsif_pkg::ADR_FLAGS_B : cpsif_pkg::ADR_FLAGS_A;
            u_ccp_mode <= (k == 3) ? cpsif_pkg::CPSIF_CCP_COMPARE : cpsif_pkg::CPSIF_CCP_CAPTURE;
            ev(8'h01 << k, 1'b0, 1'b0);
            rreg(fa, rv);
            chk8(rv, fbit(k));
            wreg(fa, 8'h00);
            rreg(fa, rv);
            chk8(rv, 8'h00);
        end
        u_ccp_mode <= cpsif_pkg::CPSIF_CCP_PWM;
        ev(8'h0c, 1'b0, 1'b0);
        rreg(cpsif_pkg::ADR_FLAGS_A, rv);
        chk8(rv, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wreg(cpsif_pkg::ADR_ENA_B, d);
            rreg(cpsif_pkg::ADR_ENA_B, rv);
            chk8(rv, d & 8'h18);
        end
        // Hardware set and software clear in the same cycle
        @(posedge ref_clk);
        {u_events, u_adr, u_wdata, u_wr} <= {8'h01, cpsif_pkg::ADR_FLAGS_A, 8'h00, 1'b1};
        @(posedge ref_clk);
        {u_events, u_wr} <= 9'h000;
        rreg(cpsif_pkg::ADR_FLAGS_A, rv);
        chk8(rv, 8'h40);
        wreg(cpsif_pkg::ADR_FLAGS_A, 8'h00); // Flags cleared before any enable
        // Interrupt needs individual, group and global enables
        wreg(cpsif_pkg::ADR_ENA_B, 8'h10);
        wreg(cpsif_pkg::ADR_GLOBAL, 8'hc0);
        ev(8'h40, 1'b0, 1'b0);
        repeat (3) @(posedge ref_clk);
        #1 chk8({7'h00, u_irq}, 8'h01);
        wreg(cpsif_pkg::ADR_GLOBAL, 8'h80);
        repeat (3) @(posedge ref_clk);
        #1 chk8({7'h00, u_irq}, 8'h00);
        wreg(cpsif_pkg::ADR_FLAGS_B, 8'h00);
        ev(8'h00, 1'b1, 1'b0);
        rreg(cpsif_pkg::ADR_RST_CAUSE, rv);
        chk8(rv, 8'h01);
        wreg(cpsif_pkg::ADR_RST_CAUSE, 8'h03); // Software sets both back
        ev(8'h00, 1'b0, 1'b1);
        rreg(cpsif_pkg::ADR_RST_CAUSE, rv);
        chk8(rv, 8'h02);
        // Frozen clock enable: an overflow event must leave no trace
        @(posedge ref_clk);
        clk_en <= 1'b0;
        ev(8'h20, 1'b0, 1'b0);
        clk_en <= 1'b1;
        @(posedge ref_clk);
        rreg(cpsif_pkg::ADR_FLAGS_A, rv);
        chk8(rv, 8'h00);
        // Counter loads, then ten pushes so the stack wraps once
        lat = 8'($random(seed));
        pc_low_byte = 8'($random(seed));
        wreg(cpsif_pkg::ADR_LATCH, lat);
        wreg(cpsif_pkg::ADR_PCL, pc_low_byte);
        epc = {lat[4:0], pc_low_byte};
        @(posedge ref_clk);
        #1 chk13(u_pc, epc);
        flow(4, 11'h000);
        flow(1, 11'($random(seed)));
        for (int i = 0; i < 10; i++) flow((i == 4) ? 2 : 0, 11'($random(seed)));
        for (int i = 0; i < 8; i++) flow(3, 11'h000);
        rreg(cpsif_pkg::ADR_LATCH, rv);
        chk8(rv, lat);
        chk8(latch_q, lat);
        // Indirect access through pointer and bank bit
        wreg(cpsif_pkg::ADR_POINTER, 8'h00);
        rreg(cpsif_pkg::ADR_INDIRECT, rv);
        chk8(rv, 8'h00);
        f0 = n_fwr;
        wreg(cpsif_pkg::ADR_INDIRECT, 8'h5a);
        repeat (2) @(posedge ref_clk);
        chk8(8'(n_fwr - f0), 8'h00);
        d = 8'h20 | (8'($random(seed)) & 8'h5f);
        u_status <= {1'($random(seed)), 7'h00};
        file_rdata <= 8'($random(seed));
        wreg(cpsif_pkg::ADR_POINTER, d);
        wreg(cpsif_pkg::ADR_INDIRECT, ~d);
        repeat (2) @(posedge ref_clk);
        chk13({4'h0, seen_adr}, {4'h0, u_status[7], d});
        chk8(seen_wd, ~d);
        chk8(pointer_q, d);
        rreg(cpsif_pkg::ADR_INDIRECT, rv);
        chk8(rv, file_rdata);
        finish_test();
    end
endmodule : tb

// >>> hw/cpsif_core.sv
// Flag/enable registers, program counter, return stack and indirect addressing
// How it works
// RQ1 - Conversion done sets flags_a bit 6
// RQ2 - Serial transfer or bus event sets bit 3
// RQ3 - Capture/compare sets bit 2, not in PWM
// RQ4 - Timer2 period match sets bit 1
// RQ5 - Timer1 rollover sets bit 0
// RQ6 - Flags set regardless of enables; software clears
// RQ7 - Software clears flags before enabling, serial before exit
// RQ8 - Enables_b holds nvm bit 4, collision bit 3
// RQ9 - Memory write completion sets flags_b bit 4
// RQ10 - Master bus collision sets flags_b bit 3
// RQ11 - Unimplemented bits read zero; reserved written zero (latch bits 7:5 are kept and read back as written)
// RQ12 - Power-on reset clears status bit 1
// RQ13 - Brown-out reset clears status bit 0
// RQ14 - Thirteen-bit counter, upper bits only via latch
// RQ15 - Low byte write loads latch bits 4:0
// RQ16 - Call/goto: 11 bits, upper from latch 4:3
// RQ17 - Every reset clears counter upper bits
// RQ18 - Eight-entry stack, push call/irq, pop returns
// RQ19 - Stack wraps circularly, no overflow status
// RQ20 - Return restores full counter; latch untouched
// RQ21 - Indirect access uses bank bit and pointer
// RQ22 - Indirect self read zero, write ignored
// RQ23 - Interrupt needs individual, group, global enables
// RQ24 - Single-cycle access; hardware set beats clear
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
module cpsif_core #(
    parameter int DEPTH = cpsif_pkg::STK_N
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    cpsif_if.core     bus,
    output logic [8:0] file_adr,
    output logic [7:0] file_wdata,
    output logic       file_wr,
    input  wire logic [7:0] file_rdata,
    output logic [7:0] pointer_q,
    output logic [7:0] latch_q
);
    localparam int AW = $clog2(DEPTH);

    logic [7:0]  flags_a;
    logic [7:0]  flags_b;
    logic [7:0]  ena_a;
    logic [7:0]  ena_b;
    logic [7:0]  rst_cause;
    logic [7:0]  ctrl;
    logic [7:0]  pointer;
    logic [7:0]  latch;
    logic [12:0] pc;
    logic [12:0] stack [DEPTH];
    logic [AW-1:0] sp;
    logic [7:0]  rdata;
    logic        irq;
    logic [8:0]  fadr_q;
    logic [7:0]  fwd_q;
    logic        fwr_q;

    // Indirect location resolves to bank bit plus pointer
    wire         is_ind     = (bus.fadr == cpsif_pkg::ADR_INDIRECT);
    wire  [8:0]  ind_adr    = {bus.status_in[cpsif_pkg::B_BANK], pointer}; // [RQ21]
    wire         ind_self   = is_ind && (ind_adr == cpsif_pkg::ADR_INDIRECT);
    wire  [8:0]  eff_adr    = is_ind ? ind_adr : bus.fadr;
    wire         wr_ok      = bus.wr && !ind_self; // [RQ22]

    function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
        hit = (a == r);
    endfunction : hit

    wire w_fa  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_FLAGS_A);
    wire w_fb  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_FLAGS_B);
    wire w_ea  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_ENA_A);
    wire w_eb  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_ENA_B);
    wire w_rc  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_RST_CAUSE);
    wire w_pcl = wr_ok && hit(eff_adr, cpsif_pkg::ADR_PCL);
    wire w_lat = wr_ok && hit(eff_adr, cpsif_pkg::ADR_LATCH);
    wire w_ptr = wr_ok && hit(eff_adr, cpsif_pkg::ADR_POINTER);
    wire w_gl  = wr_ok && hit(eff_adr, cpsif_pkg::ADR_GLOBAL);
    wire local_hit = hit(eff_adr, cpsif_pkg::ADR_FLAGS_A) || hit(eff_adr, cpsif_pkg::ADR_FLAGS_B)
                  || hit(eff_adr, cpsif_pkg::ADR_ENA_A) || hit(eff_adr, cpsif_pkg::ADR_ENA_B)
                  || hit(eff_adr, cpsif_pkg::ADR_RST_CAUSE) || hit(eff_adr, cpsif_pkg::ADR_PCL)
                  || hit(eff_adr, cpsif_pkg::ADR_LATCH) || hit(eff_adr, cpsif_pkg::ADR_POINTER)
                  || hit(eff_adr, cpsif_pkg::ADR_GLOBAL);

    // Hardware events, capture/compare qualified by mode
    wire ccp_ev = (bus.ccp_mode == cpsif_pkg::CPSIF_CCP_CAPTURE && bus.ev_ccp_capture)
               || (bus.ccp_mode == cpsif_pkg::CPSIF_CCP_COMPARE && bus.ev_ccp_compare); // [RQ3]
    wire [7:0] set_a = ({7'h00, bus.ev_conv}   << cpsif_pkg::B_CONV)   // [RQ1]
                     | ({7'h00, bus.ev_ser}    << cpsif_pkg::B_SER)    // [RQ2]
                     | ({7'h00, ccp_ev}        << cpsif_pkg::B_CCP)
                     | ({7'h00, bus.ev_period} << cpsif_pkg::B_PER)    // [RQ4]
                     | ({7'h00, bus.ev_t1_ovf} << cpsif_pkg::B_T1);    // [RQ5]
    wire [7:0] set_b = ({7'h00, bus.ev_nvm}    << cpsif_pkg::B_NVM)    // [RQ9]
                     | ({7'h00, bus.ev_bcol}   << cpsif_pkg::B_BCOL);  // [RQ10]

    // Set wins over a same-cycle software write; enables never gate a set
    wire [7:0] next_flags_a = ((w_fa ? bus.wdata : flags_a) | set_a)
                            & cpsif_pkg::FLAGS_A_MASK; // [RQ6] [RQ24] [RQ11]
    wire [7:0] next_flags_b = ((w_fb ? bus.wdata : flags_b) | set_b)
                            & cpsif_pkg::FLAGS_B_MASK; // [RQ6] [RQ24] [RQ11]

    // Reset causes clear their status bit; software sets it back
    wire [7:0] rc_w = w_rc ? (bus.wdata & cpsif_pkg::RST_MASK) : rst_cause;
    wire [7:0] next_rst_cause = rc_w
        & ~({7'h00, bus.por_event} << cpsif_pkg::B_POR)  // [RQ12]
        & ~({7'h00, bus.bor_event} << cpsif_pkg::B_BOR); // [RQ13]

    // Any enabled pending peripheral flag, gated by group and global enables
    wire pend = |((flags_a & ena_a) | (flags_b & ena_b));
    wire next_irq = pend && ctrl[cpsif_pkg::B_PERIPHERAL_GROUP_ENABLE] && ctrl[cpsif_pkg::B_GIE]; // [RQ23]

    // Program counter sources; returns leave the latch alone
    wire [AW-1:0] sp_top = sp - 1'b1;
    wire push = bus.do_call || bus.do_irq_push;
    wire [12:0] pc_inc = pc + 13'h0001;
    wire [12:0] jmp_pc = {latch[cpsif_pkg::LATCH_HI:cpsif_pkg::LATCH_PG],
                          bus.jump_target}; // [RQ16]
    wire [12:0] next_pc = bus.do_return ? stack[sp_top] :                 // [RQ20]
                          (bus.do_call || bus.do_goto) ? jmp_pc :
                          w_pcl ? {latch[cpsif_pkg::LATCH_HI:0], bus.wdata} : // [RQ15]
                          bus.do_step ? pc_inc : pc;

    // Read mux: counter upper bits are not readable, only the low byte
    wire [7:0] rd_mux = ind_self ? cpsif_pkg::ZERO_BYTE :                 // [RQ22]
        hit(eff_adr, cpsif_pkg::ADR_FLAGS_A)   ? flags_a :
        hit(eff_adr, cpsif_pkg::ADR_FLAGS_B)   ? flags_b :
        hit(eff_adr, cpsif_pkg::ADR_ENA_A)     ? ena_a :
        hit(eff_adr, cpsif_pkg::ADR_ENA_B)     ? ena_b :
        hit(eff_adr, cpsif_pkg::ADR_RST_CAUSE) ? rst_cause :
        hit(eff_adr, cpsif_pkg::ADR_PCL)       ? pc[7:0] :                // [RQ14]
        hit(eff_adr, cpsif_pkg::ADR_LATCH)     ? latch :
        hit(eff_adr, cpsif_pkg::ADR_POINTER)   ? pointer :
        hit(eff_adr, cpsif_pkg::ADR_GLOBAL)    ? ctrl : file_rdata;

    // Register file and counter; reset clears counter upper bits too
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_a   <= 8'h00;
            flags_b   <= 8'h00;
            ena_a     <= 8'h00;
            ena_b     <= 8'h00;
            rst_cause <= 8'h03;
            ctrl      <= 8'h00;
            pointer   <= 8'h00;
            latch     <= 8'h00;
            pc        <= 13'h0000; // [RQ17]
            irq       <= 1'b0;
            rdata     <= 8'h00;
        end else if (clk_en) begin
            flags_a   <= next_flags_a;
            flags_b   <= next_flags_b;
            rst_cause <= next_rst_cause;
            pc        <= next_pc;
            irq       <= next_irq;
            if (bus.rd) rdata <= rd_mux;
            if (w_ea)  ena_a   <= bus.wdata & cpsif_pkg::ENA_A_MASK;
            if (w_eb)  ena_b   <= bus.wdata & cpsif_pkg::ENA_B_MASK; // [RQ8]
            if (w_gl)  ctrl    <= bus.wdata;
            if (w_ptr) pointer <= bus.wdata;
            if (w_lat) latch   <= bus.wdata;
        end
    end

    // Circular stack: pointer wraps silently, ninth push overwrites the first
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp <= '0;
        end else if (clk_en) begin
            if (push) sp <= sp + 1'b1;               // [RQ18] [RQ19]
            else if (bus.do_return) sp <= sp_top;    // [RQ18]
        end
    end

    // Stack storage; return address is the next instruction for a call
    always_ff @(posedge ref_clk) begin
        if (clk_en && push) stack[sp] <= bus.do_call ? pc_inc : pc; // [RQ18]
    end

    // Pass-through to external file registers, registered for timing
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fadr_q <= 9'h000;
            fwd_q  <= 8'h00;
            fwr_q  <= 1'b0;
        end else if (clk_en) begin
            fadr_q <= eff_adr;
            fwd_q  <= bus.wdata;
            fwr_q  <= wr_ok && !local_hit;
        end
    end

    assign bus.rdata  = rdata;
    assign bus.pc     = pc;
    assign bus.irq    = irq;
    assign file_adr   = fadr_q;
    assign file_wdata = fwd_q;
    assign file_wr    = fwr_q;
    assign pointer_q  = pointer;
    assign latch_q    = latch;
endmodule : cpsif_core

// >>> hw/cpsif_cpu.sv
// CPU/peripheral end: turns user commands into interface strobes
`timescale 1ns/1ns
module cpsif_cpu (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    cpsif_if.cpu      bus,
    input  wire logic [8:0]  u_adr,
    input  wire logic [7:0]  u_wdata,
    input  wire logic        u_wr,
    input  wire logic        u_rd,
    input  wire logic [7:0]  u_status,
    input  wire logic        u_call,
    input  wire logic        u_goto,
    input  wire logic        u_irq_push,
    input  wire logic        u_return,
    input  wire logic        u_step,
    input  wire logic [10:0] u_target,
    input  wire logic [7:0]  u_events,
    input  wire logic [1:0]  u_ccp_mode,
    input  wire logic        u_por,
    input  wire logic        u_bor,
    output logic [7:0]  u_rdata,
    output logic [12:0] u_pc,
    output logic        u_irq
);
    logic [7:0]  rdata_q;
    logic [12:0] pc_q;
    logic        irq_q;

    // Strobes go straight through; software keeps reserved bits zero [RQ11]
    // and clears flags before enabling or leaving service [RQ7]
    assign bus.fadr           = u_adr;
    assign bus.wdata          = u_wdata;
    assign bus.wr             = u_wr;
    assign bus.rd             = u_rd;
    assign bus.status_in      = u_status;
    assign bus.do_call        = u_call;
    assign bus.do_goto        = u_goto;
    assign bus.do_irq_push    = u_irq_push;
    assign bus.do_return      = u_return;
    assign bus.do_step        = u_step;
    assign bus.jump_target    = u_target;
    assign bus.ev_conv        = u_events[0];
    assign bus.ev_ser         = u_events[1];
    assign bus.ev_ccp_capture = u_events[2];
    assign bus.ev_ccp_compare = u_events[3];
    assign bus.ev_period      = u_events[4];
    assign bus.ev_t1_ovf      = u_events[5];
    assign bus.ev_nvm         = u_events[6];
    assign bus.ev_bcol        = u_events[7]; // Collision event reachable from the user side
    assign bus.ccp_mode       = u_ccp_mode;
    assign bus.por_event      = u_por;
    assign bus.bor_event      = u_bor;

    // Outputs registered; read data lags the core's answer by one cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
            pc_q    <= 13'h0000;
            irq_q   <= 1'b0;
        end else if (clk_en) begin
            rdata_q <= bus.rdata;
            pc_q    <= bus.pc;
            irq_q   <= bus.irq;
        end
    end

    assign u_rdata = rdata_q;
    assign u_pc    = pc_q;
    assign u_irq   = irq_q;
endmodule : cpsif_cpu

// >>> inc/cpsif_if.sv
// Interface joining the CPU/peripheral end and the control block
`timescale 1ns/1ns
interface cpsif_if;
    logic [8:0]  fadr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [7:0]  status_in;
    logic        do_call;
    logic        do_goto;
    logic        do_irq_push;
    logic        do_return;
    logic        do_step;
    logic [10:0] jump_target;
    logic [12:0] pc;
    logic        irq;
    logic        ev_conv;
    logic        ev_ser;
    logic        ev_ccp_capture;
    logic        ev_ccp_compare;
    logic [1:0]  ccp_mode;
    logic        ev_period;
    logic        ev_t1_ovf;
    logic        ev_nvm;
    logic        ev_bcol;
    logic        por_event;
    logic        bor_event;
    modport core (input fadr, wdata, wr, rd, status_in, do_call, do_goto, do_irq_push,
                  do_return, do_step, jump_target, ev_conv, ev_ser, ev_ccp_capture,
                  ev_ccp_compare, ccp_mode, ev_period, ev_t1_ovf, ev_nvm, ev_bcol,
                  por_event, bor_event,
                  output rdata, pc, irq);
    modport cpu (output fadr, wdata, wr, rd, status_in, do_call, do_goto, do_irq_push,
                 do_return, do_step, jump_target, ev_conv, ev_ser, ev_ccp_capture,
                 ev_ccp_compare, ccp_mode, ev_period, ev_t1_ovf, ev_nvm, ev_bcol,
                 por_event, bor_event,
                 input rdata, pc, irq);
endinterface : cpsif_if

// >>> inc/cpsif_pkg.sv
// Constants shared by the core-side control block and its CPU/peripheral end
package cpsif_pkg;
    localparam int PC_W   = 13;
    localparam int JMP_W  = 11;
    localparam int STK_N  = 8;
    localparam int STK_AW = 3;
    localparam int FA_W   = 9;
    localparam logic [8:0] ADR_FLAGS_A  = 9'h00c;
    localparam logic [8:0] ADR_FLAGS_B  = 9'h00d;
    localparam logic [8:0] ADR_ENA_A    = 9'h08c;
    localparam logic [8:0] ADR_ENA_B    = 9'h08d;
    localparam logic [8:0] ADR_RST_CAUSE = 9'h08e;
    localparam logic [8:0] ADR_PCL      = 9'h002;
    localparam logic [8:0] ADR_LATCH    = 9'h00a;
    localparam logic [8:0] ADR_INDIRECT = 9'h000;
    localparam logic [8:0] ADR_POINTER  = 9'h004;
    localparam logic [8:0] ADR_GLOBAL   = 9'h00b;
    localparam logic [7:0] FLAGS_A_MASK = 8'h4f;
    localparam logic [7:0] FLAGS_B_MASK = 8'h18;
    localparam logic [7:0] ENA_A_MASK   = 8'h4f;
    localparam logic [7:0] ENA_B_MASK   = 8'h18;
    localparam logic [7:0] RST_MASK     = 8'h03;
    localparam int B_CONV = 6;
    localparam int B_SER  = 3;
    localparam int B_CCP  = 2;
    localparam int B_PER  = 1;
    localparam int B_T1   = 0;
    localparam int B_NVM  = 4;
    localparam int B_BCOL = 3;
    localparam int B_POR  = 1;
    localparam int B_BOR  = 0;
    localparam int B_GIE  = 7;
    localparam int B_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int B_BANK = 7;
    localparam int LATCH_HI = 4;
    localparam int LATCH_PG = 3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    typedef enum logic [1:0] {CPSIF_CCP_CAPTURE, CPSIF_CCP_COMPARE, CPSIF_CCP_PWM} cpsif_ccp_t;
endpackage : cpsif_pkg
